//--- logic/ofb_pkg.sv
package ofb_pkg;

	// Register map, byte addresses
	localparam logic [7:0] OFB_ADDR_OUTPUT_FRAME_CONTROL = 8'h10;

	// Field positions of output_frame_control
	localparam int OFB_POS_APPEND_IDENTIFIER = 14;
	localparam int OFB_POS_APPEND_SUPPLY_FLAGS = 12;
	localparam int OFB_POS_APPEND_INPUT_FLAGS = 10;
	localparam int OFB_POS_APPEND_INPUT_SPAN = 8;
	localparam int OFB_POS_PARITY_APPEND_ENABLE = 3;
	localparam int OFB_POS_OUTPUT_PATTERN_SELECT = 0;

	// Reset values
	localparam logic OFB_RST_APPEND_IDENTIFIER = 1'h0;
	localparam logic [1:0] OFB_RST_APPEND_SUPPLY_FLAGS = 2'h0;
	localparam logic [1:0] OFB_RST_APPEND_INPUT_FLAGS = 2'h0;
	localparam logic OFB_RST_APPEND_INPUT_SPAN = 1'h0;
	localparam logic OFB_RST_PARITY_APPEND_ENABLE = 1'h0;
	localparam logic [2:0] OFB_RST_OUTPUT_PATTERN_SELECT = 3'h0;

	// Frame geometry
	localparam int OFB_RESULT_W = 14;
	localparam int OFB_ID_W = 4;
	localparam int OFB_SPAN_W = 4;
	localparam int OFB_FRAME_W = 28;
	localparam int OFB_LEN_W = 5;

	// Test pattern values of the value field
	localparam logic [13:0] OFB_PAT_ZEROS = 14'h0000;
	localparam logic [13:0] OFB_PAT_ONES = 14'h3FFF;
	localparam logic [13:0] OFB_PAT_ALT_SINGLE = 14'h1555;
	localparam logic [13:0] OFB_PAT_ALT_PAIRS = 14'h0CCC;

	typedef enum logic [2:0] {
		OFB_PAT_SEL_ZEROS = 3'b100,
		OFB_PAT_SEL_ONES = 3'b101,
		OFB_PAT_SEL_ALT1 = 3'b110,
		OFB_PAT_SEL_ALT2 = 3'b111
	} ofb_pattern_t;

	typedef struct packed {
		logic append_identifier;
		logic [1:0] append_supply_flags;
		logic [1:0] append_input_flags;
		logic append_input_span;
		logic parity_append_enable;
		logic [2:0] output_pattern_select;
	} ofb_frame_ctl_t;

	typedef struct packed {
		logic supply_hi;
		logic supply_lo;
		logic input_hi;
		logic input_lo;
	} ofb_alarm_flags_t;

	typedef enum logic [0:0] {
		OFB_SH_IDLE = 1'b0,
		OFB_SH_SHIFT = 1'b1
	} ofb_shift_state_t;

endpackage

//--- logic/ofb_frame_packer.sv
`timescale 1ns/10ps
`default_nettype none
module ofb_frame_packer
	import ofb_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic pack_req,
	input wire ofb_frame_ctl_t ctl,
	input wire logic [OFB_RESULT_W-1:0] result,
	input wire logic [OFB_ID_W-1:0] device_id,
	input wire logic [OFB_SPAN_W-1:0] range_sel,
	input wire ofb_alarm_flags_t alarms,
	output logic pack_valid_r,
	output logic [OFB_FRAME_W-1:0] pack_frame_r,
	output logic [OFB_LEN_W-1:0] pack_len_r
);

	logic [OFB_RESULT_W-1:0] value_nxt;
	logic [OFB_FRAME_W-1:0] acc_nxt;
	logic [OFB_LEN_W-1:0] len_nxt;
	logic par_value;
	logic par_frame;

	always_comb begin
		case (ctl.output_pattern_select)
			OFB_PAT_SEL_ZEROS: value_nxt = OFB_PAT_ZEROS;
			OFB_PAT_SEL_ONES: value_nxt = OFB_PAT_ONES;
			OFB_PAT_SEL_ALT1: value_nxt = OFB_PAT_ALT_SINGLE;
			OFB_PAT_SEL_ALT2: value_nxt = OFB_PAT_ALT_PAIRS;
			default: value_nxt = result;
		endcase
	end

	// Right-aligned build, each enabled field pushed in at the bottom
	always_comb begin
		acc_nxt = {{(OFB_FRAME_W-OFB_RESULT_W){1'b0}}, value_nxt};
		len_nxt = OFB_LEN_W'(OFB_RESULT_W);
		par_value = ^value_nxt;
		if (ctl.append_identifier) begin
			acc_nxt = {acc_nxt[OFB_FRAME_W-OFB_ID_W-1:0], device_id};
			len_nxt = len_nxt + OFB_LEN_W'(OFB_ID_W);
		end
		case (ctl.append_supply_flags)
			2'h1: begin
				acc_nxt = {acc_nxt[OFB_FRAME_W-2:0], alarms.supply_hi};
				len_nxt = len_nxt + 5'h01;
			end
			2'h2: begin
				acc_nxt = {acc_nxt[OFB_FRAME_W-2:0], alarms.supply_lo};
				len_nxt = len_nxt + 5'h01;
			end
			2'h3: begin
				acc_nxt = {acc_nxt[OFB_FRAME_W-3:0], alarms.supply_hi, alarms.supply_lo};
				len_nxt = len_nxt + 5'h02;
			end
			default: begin
			end
		endcase
		case (ctl.append_input_flags)
			2'h1: begin
				acc_nxt = {acc_nxt[OFB_FRAME_W-2:0], alarms.input_hi};
				len_nxt = len_nxt + 5'h01;
			end
			2'h2: begin
				acc_nxt = {acc_nxt[OFB_FRAME_W-2:0], alarms.input_lo};
				len_nxt = len_nxt + 5'h01;
			end
			2'h3: begin
				acc_nxt = {acc_nxt[OFB_FRAME_W-3:0], alarms.input_hi, alarms.input_lo};
				len_nxt = len_nxt + 5'h02;
			end
			default: begin
			end
		endcase
		if (ctl.append_input_span) begin
			acc_nxt = {acc_nxt[OFB_FRAME_W-OFB_SPAN_W-1:0], range_sel};
			len_nxt = len_nxt + OFB_LEN_W'(OFB_SPAN_W);
		end
		// Unused upper bits are zero, so reducing the whole word is safe
		par_frame = ^acc_nxt;
		if (ctl.parity_append_enable) begin
			acc_nxt = {acc_nxt[OFB_FRAME_W-3:0], par_value, par_frame};
			len_nxt = len_nxt + 5'h02;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pack_valid_r <= 1'b0;
		end else if (clk_en) begin
			pack_valid_r <= pack_req;
		end
	end

	// Stored MSB-aligned so the serializer always starts at the top bit
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pack_frame_r <= '0;
			pack_len_r <= '0;
		end else if (clk_en && pack_req) begin
			pack_frame_r <= acc_nxt << (OFB_LEN_W'(OFB_FRAME_W) - len_nxt);
			pack_len_r <= len_nxt;
		end
	end

endmodule
`default_nettype wire

//--- logic/ofb_output_frame_builder.sv
// Contract
// - When append_identifier is set the 4-bit device identifier goes into the frame, else not.
// - append_supply_flags adds nothing, the high flag, the low flag or both for 00/01/10/11.
// - append_input_flags adds nothing, the high flag, the low flag or both for 00/01/10/11.
// - When append_input_span is set the 4-bit range setting goes into the frame, else not.
// - parity_append_enable adds two parity bits at the frame's end, making it two bits longer.
// - The first parity bit is even parity over the conversion value bits only.
// - The second parity bit is even parity over the whole frame with all appended fields.
// - The value parity bit is not part of the frame parity computation.
// - With pattern select 0xx the value field carries the real conversion result.
// - Pattern select 100 sends all zeros and 101 sends all ones in the value field.
// - Pattern select 110 sends alternating 0 and 1, and 111 sends alternating 00 and 11.
// - Reserved bits 31-16, 15, 9 and 7-4 of output_frame_control read as zero.
// - Each appended alarm flag is 1 while its condition exists and 0 otherwise.
// - The appended range is the 4-bit range selection held by the range configuration.
`timescale 1ns/10ps
`default_nettype none
module ofb_output_frame_builder
	import ofb_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [OFB_ID_W-1:0] device_id,
	input wire logic [OFB_SPAN_W-1:0] range_sel,
	input wire ofb_alarm_flags_t alarms,
	input wire logic conv_valid,
	input wire logic [OFB_RESULT_W-1:0] conv_data,
	input wire logic shift_bit,
	output logic serial_out_lines,
	output logic frame_valid,
	output logic frame_busy,
	output logic [OFB_LEN_W-1:0] frame_len,
	output logic [OFB_FRAME_W-1:0] frame_data
);

	ofb_frame_ctl_t ctl_r;
	logic hit;
	logic [31:0] rd_word;
	logic pack_valid;
	logic [OFB_FRAME_W-1:0] pack_frame;
	logic [OFB_LEN_W-1:0] pack_len;
	ofb_shift_state_t sh_state_r;
	logic [OFB_FRAME_W-1:0] shift_r;
	logic [OFB_LEN_W-1:0] left_r;
	logic [31:0] rdata_r;
	logic valid_r;
	logic [OFB_LEN_W-1:0] len_r;
	logic [OFB_FRAME_W-1:0] data_r;
	logic busy_r;

	assign hit = (reg_addr == OFB_ADDR_OUTPUT_FRAME_CONTROL);

	// Control register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_r.append_identifier <= OFB_RST_APPEND_IDENTIFIER;
			ctl_r.append_supply_flags <= OFB_RST_APPEND_SUPPLY_FLAGS;
			ctl_r.append_input_flags <= OFB_RST_APPEND_INPUT_FLAGS;
			ctl_r.append_input_span <= OFB_RST_APPEND_INPUT_SPAN;
			ctl_r.parity_append_enable <= OFB_RST_PARITY_APPEND_ENABLE;
			ctl_r.output_pattern_select <= OFB_RST_OUTPUT_PATTERN_SELECT;
		end else if (clk_en && reg_wr && hit) begin
			ctl_r.append_identifier <= reg_wdata[OFB_POS_APPEND_IDENTIFIER];
			ctl_r.append_supply_flags <= reg_wdata[OFB_POS_APPEND_SUPPLY_FLAGS +: 2];
			ctl_r.append_input_flags <= reg_wdata[OFB_POS_APPEND_INPUT_FLAGS +: 2];
			ctl_r.append_input_span <= reg_wdata[OFB_POS_APPEND_INPUT_SPAN];
			ctl_r.parity_append_enable <= reg_wdata[OFB_POS_PARITY_APPEND_ENABLE];
			ctl_r.output_pattern_select <= reg_wdata[OFB_POS_OUTPUT_PATTERN_SELECT +: 3];
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		if (hit) begin
			rd_word[OFB_POS_APPEND_IDENTIFIER] = ctl_r.append_identifier;
			rd_word[OFB_POS_APPEND_SUPPLY_FLAGS +: 2] = ctl_r.append_supply_flags;
			rd_word[OFB_POS_APPEND_INPUT_FLAGS +: 2] = ctl_r.append_input_flags;
			rd_word[OFB_POS_APPEND_INPUT_SPAN] = ctl_r.append_input_span;
			rd_word[OFB_POS_PARITY_APPEND_ENABLE] = ctl_r.parity_append_enable;
			rd_word[OFB_POS_OUTPUT_PATTERN_SELECT +: 3] = ctl_r.output_pattern_select;
		end
	end

	// Unmapped reads return zero
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 32'h00000000;
		end else if (clk_en && reg_rd) begin
			rdata_r <= rd_word;
		end
	end

	// Control and flags are taken in the conv_valid cycle, live at that moment
	ofb_frame_packer u_packer (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pack_req(conv_valid),
		.ctl(ctl_r),
		.result(conv_data),
		.device_id(device_id),
		.range_sel(range_sel),
		.alarms(alarms),
		.pack_valid_r(pack_valid),
		.pack_frame_r(pack_frame),
		.pack_len_r(pack_len)
	);

	// Published frame copy for parallel readers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			valid_r <= 1'b0;
			len_r <= '0;
			data_r <= '0;
		end else if (clk_en) begin
			valid_r <= pack_valid;
			if (pack_valid) begin
				len_r <= pack_len;
				data_r <= pack_frame;
			end
		end
	end

	// Serializer: a new frame aborts any frame still being shifted,
	// the host is expected to read a frame before the next conversion.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sh_state_r <= OFB_SH_IDLE;
			shift_r <= '0;
			left_r <= '0;
		end else if (clk_en) begin
			case (sh_state_r)
				OFB_SH_IDLE: begin
					if (pack_valid) begin
						sh_state_r <= OFB_SH_SHIFT;
						shift_r <= pack_frame;
						left_r <= pack_len;
					end
				end
				OFB_SH_SHIFT: begin
					if (pack_valid) begin
						shift_r <= pack_frame;
						left_r <= pack_len;
					end else if (shift_bit) begin
						shift_r <= {shift_r[OFB_FRAME_W-2:0], 1'b0};
						left_r <= left_r - 5'h01;
						if (left_r == 5'h01) begin
							sh_state_r <= OFB_SH_IDLE;
						end
					end
				end
				default: sh_state_r <= OFB_SH_IDLE;
			endcase
		end
	end

	// Own flop so the busy pin is registered, mirrors the shifter state
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
		end else if (clk_en) begin
			if (pack_valid) begin
				busy_r <= 1'b1;
			end else if (busy_r && shift_bit && left_r == 5'h01) begin
				busy_r <= 1'b0;
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign serial_out_lines = shift_r[OFB_FRAME_W-1];
	assign frame_busy = busy_r;
	assign frame_valid = valid_r;
	assign frame_len = len_r;
	assign frame_data = data_r;

	// Checking helpers
	logic [OFB_LEN_W-1:0] exp_len;
	logic [OFB_FRAME_W-1:0] tail;

	always_comb begin
		exp_len = OFB_LEN_W'(OFB_RESULT_W);
		if (ctl_r.append_identifier) begin
			exp_len = exp_len + 5'h04;
		end
		exp_len = exp_len + {4'h0, ctl_r.append_supply_flags[1]}
			+ {4'h0, ctl_r.append_supply_flags[0]};
		exp_len = exp_len + {4'h0, ctl_r.append_input_flags[1]}
			+ {4'h0, ctl_r.append_input_flags[0]};
		if (ctl_r.append_input_span) begin
			exp_len = exp_len + 5'h04;
		end
		if (ctl_r.parity_append_enable) begin
			exp_len = exp_len + 5'h02;
		end
	end

	assign tail = data_r >> (OFB_LEN_W'(OFB_FRAME_W) - len_r);

	AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && reg_rd && hit |=> rdata_r[31:15] == 17'h00000 && rdata_r[9] == 1'b0
			&& rdata_r[7:4] == 4'h0)
		else $error("reserved control bits read nonzero");

	AST_RESET_DEFAULT: assert property (@(posedge clock) disable iff (sys_rst)
		$past(sys_rst) |-> ctl_r == '0)
		else $error("control fields not zero after reset");

	AST_LENGTH: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && !reg_wr ##1 clk_en ##1 clk_en |-> valid_r
			&& len_r == $past(exp_len, 2))
		else $error("frame length does not match control");

	AST_DATA_PASS: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && !ctl_r.output_pattern_select[2] ##1 clk_en ##1 clk_en
			|-> data_r[OFB_FRAME_W-1 -: OFB_RESULT_W] == $past(conv_data, 2))
		else $error("value field is not the conversion result");

	AST_PAT_FIXED: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && ctl_r.output_pattern_select[2:1] == 2'b10
			##1 clk_en ##1 clk_en |-> data_r[OFB_FRAME_W-1 -: OFB_RESULT_W]
			== {OFB_RESULT_W{$past(ctl_r.output_pattern_select[0], 2)}})
		else $error("fixed pattern wrong");

	AST_PAT_ALT: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && ctl_r.output_pattern_select == OFB_PAT_SEL_ALT2
			##1 clk_en ##1 clk_en |-> data_r[OFB_FRAME_W-1 -: OFB_RESULT_W] == OFB_PAT_ALT_PAIRS)
		else $error("pair pattern wrong");

	AST_VALUE_PARITY: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && ctl_r.parity_append_enable ##1 clk_en ##1 clk_en
			|-> tail[1] == ^data_r[OFB_FRAME_W-1 -: OFB_RESULT_W])
		else $error("value parity bit wrong");

	AST_FRAME_PARITY: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && ctl_r.parity_append_enable ##1 clk_en ##1 clk_en
			|-> tail[0] == ^(tail >> 2))
		else $error("frame parity bit wrong");

	AST_IDENTIFIER: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && ctl_r.append_identifier ##1 clk_en ##1 clk_en
			|-> data_r[OFB_FRAME_W-OFB_RESULT_W-1 -: OFB_ID_W] == $past(device_id, 2))
		else $error("identifier field wrong");

	AST_SUPPLY_FLAG: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && !ctl_r.append_identifier && ctl_r.append_supply_flags == 2'h2
			##1 clk_en ##1 clk_en
			|-> data_r[OFB_FRAME_W-OFB_RESULT_W-1] == $past(alarms.supply_lo, 2))
		else $error("supply flag field wrong");

	AST_SERIAL_START: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && valid_r |-> frame_busy && serial_out_lines == data_r[OFB_FRAME_W-1])
		else $error("serial output does not start at the value MSB");

	AST_PAT_SINGLE: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && ctl_r.output_pattern_select == OFB_PAT_SEL_ALT1
			##1 clk_en ##1 clk_en
			|-> data_r[OFB_FRAME_W-1 -: OFB_RESULT_W] == OFB_PAT_ALT_SINGLE)
		else $error("single alternating pattern wrong");

	AST_BOTH_FLAGS: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && !ctl_r.append_identifier
			&& ctl_r.append_supply_flags == 2'h3 && ctl_r.append_input_flags == 2'h3
			##1 clk_en ##1 clk_en
			|-> data_r[OFB_FRAME_W-OFB_RESULT_W-1 -: 4] == $past(alarms, 2))
		else $error("alarm flag fields wrong");

	AST_SPAN: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && conv_valid && !ctl_r.append_identifier
			&& ctl_r.append_supply_flags == 2'h0 && ctl_r.append_input_flags == 2'h0
			&& ctl_r.append_input_span ##1 clk_en ##1 clk_en
			|-> data_r[OFB_FRAME_W-OFB_RESULT_W-1 -: OFB_SPAN_W] == $past(range_sel, 2))
		else $error("range field wrong");

	AST_SHIFT_NEXT: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && frame_busy && shift_bit && !pack_valid
			|=> serial_out_lines == $past(shift_r[OFB_FRAME_W-2]))
		else $error("serial output skipped or repeated a bit");

	AST_BUSY_END: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && frame_busy && shift_bit && !pack_valid && left_r == 5'h01
			|=> !frame_busy && !serial_out_lines)
		else $error("frame did not end after its last bit");

	AST_HOLD_DISABLED: assert property (@(posedge clock) disable iff (sys_rst)
		!clk_en |=> $stable(shift_r) && $stable(left_r) && $stable(busy_r)
			&& $stable(ctl_r) && $stable(data_r))
		else $error("state moved while the clock enable was low");

	AST_BUSY_STATE: assert property (@(posedge clock) disable iff (sys_rst)
		frame_busy == (sh_state_r == OFB_SH_SHIFT))
		else $error("busy flag disagrees with the shifter state");

	AST_IDLE_OUT: assert property (@(posedge clock) disable iff (sys_rst)
		!frame_busy |-> !serial_out_lines)
		else $error("serial output not low between frames");

	AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && reg_rd && !hit |=> rdata_r == 32'h00000000)
		else $error("unmapped read returned data");

endmodule
`default_nettype wire

//--- tb/ofb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ofb_host_model
	import ofb_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic slow,
	input wire logic frame_valid,
	input wire logic frame_busy,
	input wire logic [OFB_LEN_W-1:0] frame_len,
	input wire logic serial_out_lines,
	output logic shift_bit,
	output logic [OFB_FRAME_W-1:0] got_r,
	output logic done_r
);
	logic [OFB_LEN_W-1:0] cnt_r;
	logic [OFB_LEN_W-1:0] len_r;
	logic taken;
	logic [OFB_LEN_W-1:0] cnt_nxt;

	assign taken = clk_en && shift_bit && frame_busy;
	assign cnt_nxt = taken ? cnt_r + 5'h01 : cnt_r;

	// Slow mode leaves a gap cycle between requests to test a stalling reader
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= '0;
			len_r <= '0;
			got_r <= '0;
			done_r <= 1'b0;
			shift_bit <= 1'b0;
		end else if (clk_en && frame_valid) begin
			// A shift taken in the publish cycle already moves the new frame
			cnt_r <= {{(OFB_LEN_W-1){1'b0}}, taken};
			len_r <= frame_len;
			got_r <= {{(OFB_FRAME_W-1){1'b0}}, taken && serial_out_lines};
			done_r <= 1'b0;
			shift_bit <= 1'b1;
		end else if (clk_en) begin
			if (taken) begin
				got_r <= {got_r[OFB_FRAME_W-2:0], serial_out_lines};
				done_r <= (cnt_nxt == len_r);
			end
			cnt_r <= cnt_nxt;
			shift_bit <= (cnt_nxt < len_r) && (!slow || !shift_bit);
		end
	end
endmodule
`default_nettype wire

//--- tb/ofb_output_frame_builder_test.sv
`timescale 1ns/10ps
`default_nettype none
module ofb_output_frame_builder_test
	import ofb_pkg::*;
;
	typedef struct packed {
		logic [31:0] ctl;
		logic [13:0] conv;
		logic [3:0] id;
		logic [3:0] span;
		logic [3:0] alm;
		logic [4:0] len;
	} ofb_row_t;

	logic clock = 1'b0;
	logic sys_rst, clk_en, reg_wr, reg_rd, conv_valid, shift_bit, serial_out_lines;
	logic frame_valid, frame_busy, slow, done, held;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_w;
	logic [3:0] device_id, range_sel;
	ofb_alarm_flags_t alarms;
	logic [13:0] conv_data;
	logic [4:0] frame_len;
	logic [27:0] frame_data, got;
	int err_total = 0;
	int samples_checked = 0;
	ofb_row_t rows [12] = '{
		'{32'h0, 14'h2A5B, 4'hA, 4'h3, 4'hF, 5'h0E}, '{32'h4000, 14'h1234, 4'h9, 4'h0, 4'h0, 5'h12},
		'{32'h1000, 14'h3001, 4'h0, 4'h0, 4'h8, 5'h0F}, '{32'h2400, 14'h0F0F, 4'h0, 4'h0, 4'h6, 5'h10},
		'{32'h3C00, 14'h0001, 4'h0, 4'h0, 4'h5, 5'h12}, '{32'h0800, 14'h2222, 4'h0, 4'h0, 4'hE, 5'h0F},
		'{32'h0108, 14'h1357, 4'h0, 4'h9, 4'h0, 5'h14}, '{32'h000C, 14'h3FFF, 4'h0, 4'h0, 4'h0, 5'h10},
		'{32'h0005, 14'h0000, 4'h0, 4'h0, 4'h0, 5'h0E}, '{32'h000E, 14'h0ABC, 4'h0, 4'h0, 4'h0, 5'h10},
		'{32'h0007, 14'h3333, 4'h0, 4'h0, 4'h0, 5'h0E}, '{32'hFFFFFFFB, 14'h2B6D, 4'h6, 4'hB, 4'hA, 5'h1C}
	};

	always #5 clock = ~clock;

	ofb_output_frame_builder dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .device_id(device_id), .range_sel(range_sel), .alarms(alarms),
		.conv_valid(conv_valid), .conv_data(conv_data), .shift_bit(shift_bit),
		.serial_out_lines(serial_out_lines), .frame_valid(frame_valid), .frame_busy(frame_busy),
		.frame_len(frame_len), .frame_data(frame_data));

	ofb_host_model host_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .slow(slow),
		.frame_valid(frame_valid), .frame_busy(frame_busy), .frame_len(frame_len),
		.serial_out_lines(serial_out_lines), .shift_bit(shift_bit), .got_r(got), .done_r(done));

	// Right-aligned frame as the host should collect it
	function automatic logic [27:0] expect_frame(ofb_row_t r);
		logic [13:0] v;
		logic [27:0] f;
		case (r.ctl[2:0])
			3'b100: v = OFB_PAT_ZEROS;
			3'b101: v = OFB_PAT_ONES;
			3'b110: v = OFB_PAT_ALT_SINGLE;
			3'b111: v = OFB_PAT_ALT_PAIRS;
			default: v = r.conv;
		endcase
		f = {14'h0, v};
		if (r.ctl[14]) f = {f[23:0], r.id};
		if (r.ctl[12]) f = {f[26:0], r.alm[3]};
		if (r.ctl[13]) f = {f[26:0], r.alm[2]};
		if (r.ctl[10]) f = {f[26:0], r.alm[1]};
		if (r.ctl[11]) f = {f[26:0], r.alm[0]};
		if (r.ctl[8]) f = {f[23:0], r.span};
		if (r.ctl[3]) f = {f[25:0], ^v, ^f};
		return f;
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic miss(string m);
		err_total++;
		$display("unexpected at %0t: %s", $time, m);
	endtask

	task automatic cmp_word(logic [31:0] g, logic [31:0] e, string m);
		samples_checked++;
		if (g !== e) miss(m);
	endtask

	task automatic cmp_frame(logic [27:0] g, logic [27:0] e, string m);
		samples_checked++;
		if (g !== e) miss(m);
	endtask

	task automatic cmp_bit(logic g, logic e, string m);
		samples_checked++;
		if (g !== e) miss(m);
	endtask

	task automatic reg_write(logic [7:0] a, logic [31:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask

	task automatic reg_read(logic [7:0] a, output logic [31:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask

	task automatic run_frame(ofb_row_t r);
		logic [27:0] e;
		logic [27:0] el;
		int n;
		e = expect_frame(r);
		el = e << (OFB_FRAME_W - int'(r.len));
		@(negedge clock);
		conv_data = r.conv;
		device_id = r.id;
		range_sel = r.span;
		alarms = ofb_alarm_flags_t'(r.alm);
		conv_valid = 1'b1;
		@(negedge clock);
		conv_valid = 1'b0;
		@(negedge clock);
		cmp_bit(frame_valid, 1'b1, "frame_valid not two cycles after conversion");
		cmp_word({27'h0, frame_len}, {27'h0, r.len}, "frame length");
		cmp_frame(frame_data, el, "parallel frame");
		cmp_bit(serial_out_lines, el[27], "first serial bit");
		@(negedge clock);
		for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clock);
		if (n == 100) begin
			miss("host never finished the frame");
			stop_test();
		end
		cmp_frame(got, e, "serial frame");
		repeat (2) @(negedge clock);
		cmp_bit(frame_busy, 1'b0, "busy after last bit");
	endtask

	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		{reg_wr, reg_rd, conv_valid, slow} = '0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		{device_id, range_sel, conv_data} = '0;
		alarms = '0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		reg_read(OFB_ADDR_OUTPUT_FRAME_CONTROL, rd_w);
		cmp_word(rd_w, 32'h0, "control after power-up");
		foreach (rows[i]) begin
			slow = i[0];
			reg_write(OFB_ADDR_OUTPUT_FRAME_CONTROL, rows[i].ctl);
			reg_read(OFB_ADDR_OUTPUT_FRAME_CONTROL, rd_w);
			cmp_word(rd_w, rows[i].ctl & 32'h00007D0F, "control readback");
			run_frame(rows[i]);
			$display("row %0d done", i);
		end
		// Unmapped place must neither take writes nor alias the control word
		reg_write(8'h14, 32'hFFFFFFFF);
		reg_read(8'h14, rd_w);
		cmp_word(rd_w, 32'h0, "unmapped read");
		reg_read(OFB_ADDR_OUTPUT_FRAME_CONTROL, rd_w);
		cmp_word(rd_w, 32'h00007D0B, "control after unmapped write");
		$display("unmapped test done");
		// A new conversion mid-shift aborts the running frame
		@(negedge clock);
		conv_valid = 1'b1;
		@(negedge clock);
		conv_valid = 1'b0;
		repeat (5) @(negedge clock);
		run_frame(rows[11]);
		$display("abort test done");
		@(negedge clock);
		sys_rst = 1'b1;
		@(negedge clock);
		cmp_frame(frame_data, 28'h0, "frame data during reset");
		cmp_word({27'h0, frame_len}, 32'h0, "frame length during reset");
		cmp_word(reg_rdata, 32'h0, "read data during reset");
		cmp_bit(frame_busy || frame_valid || serial_out_lines, 1'b0, "link during reset");
		sys_rst = 1'b0;
		reg_read(OFB_ADDR_OUTPUT_FRAME_CONTROL, rd_w);
		cmp_word(rd_w, 32'h0, "control after reset");
		run_frame(rows[0]);
		$display("reset test done");
		// Enable low mid-frame must neither lose nor repeat a bit
		reg_write(OFB_ADDR_OUTPUT_FRAME_CONTROL, rows[6].ctl);
		fork
			run_frame(rows[6]);
			begin
				repeat (8) @(negedge clock);
				clk_en = 1'b0;
				held = serial_out_lines;
				repeat (3) @(negedge clock);
				cmp_bit(serial_out_lines, held, "serial bit moved while disabled");
				cmp_bit(frame_busy, 1'b1, "busy lost while disabled");
				clk_en = 1'b1;
			end
		join
		$display("freeze test done");
		stop_test();
	end
endmodule
`default_nettype wire
